//--- rtl/tsm_dev_port.sv
// One read or write cycle on the device's parallel register pins
`timescale 1ns/1ns
`default_nettype none
module tsm_dev_port (
  input  wire logic                  ref_clk,
  input  wire logic                  reset_n,
  input  wire logic                  req,
  input  wire tsm_pkg::tsm_dev_req_t reqInfo,
  output logic                       ack,
  output logic [7:0]                 rdData,
  output logic                       devCsN,
  output logic                       devWrN,
  output logic                       devRdN,
  output logic [1:0]                 devSel,
  output logic [7:0]                 devDataOut,
  output logic                       devDataOe,
  input  wire logic [7:0]            devDataIn
);
  typedef enum logic [1:0] {PIDLE = 2'b00, PSETUP = 2'b01, PSTROBE = 2'b11, PRECOVER = 2'b10} tsm_port_t;

  tsm_port_t   state_r;
  logic [7:0]  cnt_r;
  logic        isWr_r;
  logic [7:0]  syncA_r;
  logic [7:0]  syncB_r;
  wire         cntEnd = (cnt_r == 8'h00);
  wire         strobeEnd = (state_r == PSTROBE) && cntEnd;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      syncA_r <= 8'h00;
      syncB_r <= 8'h00;
    end else begin
      syncA_r <= devDataIn;
      syncB_r <= syncA_r;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r    <= PIDLE;
      cnt_r      <= 8'h00;
      isWr_r     <= 1'b0;
      devCsN     <= 1'b1;
      devWrN     <= 1'b1;
      devRdN     <= 1'b1;
      devSel     <= 2'h0;
      devDataOut <= 8'h00;
      devDataOe  <= 1'b0;
      rdData     <= 8'h00;
      ack        <= 1'b0;
    end else begin
      ack <= 1'b0;
      unique case (state_r)
        PIDLE: if (req) begin
          state_r    <= PSETUP;
          isWr_r     <= reqInfo.wr;
          devCsN     <= 1'b0;
          devSel     <= reqInfo.sel;
          devDataOut <= reqInfo.data;
          devDataOe  <= reqInfo.wr;
        end
        PSETUP: begin
          state_r <= PSTROBE;
          cnt_r   <= 8'(tsm_pkg::STROBE_CYC - 1);
          devWrN  <= !isWr_r;
          devRdN  <= isWr_r;
        end
        PSTROBE: if (strobeEnd) begin
          // Sampled after the synchroniser, so data must settle two cycles early
          if (!isWr_r) rdData <= syncB_r;
          devWrN  <= 1'b1;
          devRdN  <= 1'b1;
          ack     <= 1'b1;
          state_r <= PRECOVER;
          cnt_r   <= 8'(tsm_pkg::RECOVER_CYC - 1);
        end else begin
          cnt_r <= cnt_r - 8'h01;
        end
        PRECOVER: begin
          devCsN    <= 1'b1;
          devDataOe <= 1'b0;
          if (cntEnd) state_r <= PIDLE;
          else cnt_r <= cnt_r - 8'h01;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

//--- rtl/tsm_host_ctrl.sv
// Host controller issuing memory access commands to the time-slot switch
`timescale 1ns/1ns
`default_nettype none
module tsm_host_ctrl (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic [3:0]  busAddr,
  input  wire logic [31:0] busWdata,
  input  wire logic        busWr,
  input  wire logic        busRd,
  output logic [31:0]      busRdata,
  output logic             devCsN,
  output logic             devWrN,
  output logic             devRdN,
  output logic [1:0]       devSel,
  output logic [7:0]       devDataOut,
  output logic             devDataOe,
  input  wire logic [7:0]  devDataIn
);
  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_WDAT = 3'b001, S_WADR = 3'b011, S_WCMD = 3'b010,
    S_POLL = 3'b110, S_RSLT = 3'b111, S_FIN = 3'b101
  } tsm_state_t;

  tsm_state_t            state_r;
  tsm_state_t            state_nxt;
  logic [7:0]            dataReg_r;
  logic [7:0]            addrReg_r;
  logic [7:0]            cmdReg_r;
  logic [7:0]            result_r;
  logic                  done_r;
  logic                  timeout_r;
  logic                  rejected_r;
  logic [9:0]            pollCnt_r;
  tsm_pkg::tsm_dev_req_t req;
  logic                  portAck;
  logic [7:0]            portData;

  wire        busy      = (state_r != S_IDLE);
  wire        wrData    = busWr && busAddr == tsm_pkg::HOST_OFS_DATA && !busy;
  wire        wrAddr    = busWr && busAddr == tsm_pkg::HOST_OFS_ADDR && !busy;
  wire        wrCmd     = busWr && busAddr == tsm_pkg::HOST_OFS_CMD;
  wire        wrStatus  = busWr && busAddr == tsm_pkg::HOST_OFS_STATUS;
  wire [7:0]  newOp     = busWdata[7:0];
  wire        launch    = wrCmd && !busy && tsm_pkg::op_is_known(newOp);
  wire        reject    = (wrCmd && (busy || !tsm_pkg::op_is_known(newOp)))
                       || (busWr && busy && (busAddr == tsm_pkg::HOST_OFS_DATA
                                          || busAddr == tsm_pkg::HOST_OFS_ADDR));
  wire        cmdIsRead = tsm_pkg::op_is_read(cmdReg_r);
  // Reads need no data; the broadcast tristate write needs data but no address
  wire        needAddr  = cmdReg_r != tsm_pkg::OP_TRI_ALL;
  wire        devBusy   = portData[tsm_pkg::DEV_BUSY_BIT];
  wire        pollLast  = pollCnt_r == 10'(tsm_pkg::POLL_LIMIT - 1);
  // Code and tristate reads carry only a nibble; upper bits are undefined
  wire        nibbleRes = cmdReg_r == tsm_pkg::OP_CODE_READ
                       || cmdReg_r == tsm_pkg::OP_TRI_READ;
  wire [7:0]  resMasked = nibbleRes ? (portData & tsm_pkg::NIBBLE_MASK) : portData;
  wire        accState  = state_r inside {S_WDAT, S_WADR, S_WCMD, S_POLL, S_RSLT};

  // Sequence: data, address, command, then poll busy, then fetch result
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      S_IDLE: if (launch) begin
        state_nxt = S_WDAT;
        if (!tsm_pkg::op_is_known(newOp)) state_nxt = S_IDLE;
        else if (tsm_pkg::op_is_read(newOp)) state_nxt = S_WADR;
      end
      S_WDAT: if (portAck) state_nxt = needAddr ? S_WADR : S_WCMD;
      S_WADR: if (portAck) state_nxt = S_WCMD;
      S_WCMD: if (portAck) state_nxt = S_POLL;
      S_POLL: if (portAck) begin
        if (!devBusy) state_nxt = cmdIsRead ? S_RSLT : S_FIN;
        else if (pollLast) state_nxt = S_FIN;
      end
      S_RSLT: if (portAck) state_nxt = S_FIN;
      S_FIN:  state_nxt = S_IDLE;
      default: state_nxt = S_IDLE;
    endcase
  end

  // Device pin request for the current step
  always_comb begin
    req.wr   = 1'b1;
    req.sel  = tsm_pkg::DEV_SEL_DATA;
    req.data = dataReg_r;
    unique case (state_r)
      S_WADR: begin
        req.sel  = tsm_pkg::DEV_SEL_ADDR;
        req.data = addrReg_r;
      end
      S_WCMD: begin
        req.sel  = tsm_pkg::DEV_SEL_CMD;
        req.data = cmdReg_r;
      end
      S_POLL: begin
        req.wr  = 1'b0;
        req.sel = tsm_pkg::DEV_SEL_STATUS;
      end
      S_RSLT: begin
        req.wr  = 1'b0;
        req.sel = tsm_pkg::DEV_SEL_DATA;
      end
      default: req.wr = 1'b1;
    endcase
  end

  tsm_dev_port u_port (
    .ref_clk    (ref_clk),
    .reset_n    (reset_n),
    .req        (accState),
    .reqInfo    (req),
    .ack        (portAck),
    .rdData     (portData),
    .devCsN     (devCsN),
    .devWrN     (devWrN),
    .devRdN     (devRdN),
    .devSel     (devSel),
    .devDataOut (devDataOut),
    .devDataOe  (devDataOe),
    .devDataIn  (devDataIn)
  );

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r   <= S_IDLE;
      pollCnt_r <= 10'h000;
    end else begin
      state_r <= state_nxt;
      if (state_r != S_POLL) pollCnt_r <= 10'h000;
      else if (portAck) pollCnt_r <= pollCnt_r + 10'h001;
    end
  end

  // Order registers are frozen while a sequence runs
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      dataReg_r <= tsm_pkg::HOST_RESET_BYTE;
      addrReg_r <= tsm_pkg::HOST_RESET_BYTE;
      cmdReg_r  <= tsm_pkg::HOST_RESET_BYTE;
    end else begin
      if (wrData) dataReg_r <= busWdata[7:0];
      if (wrAddr) addrReg_r <= busWdata[7:0];
      if (launch) cmdReg_r <= newOp;
    end
  end

  // Status flags: hardware set wins over software clear
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      result_r   <= tsm_pkg::HOST_RESET_BYTE;
      done_r     <= 1'b0;
      timeout_r  <= 1'b0;
      rejected_r <= 1'b0;
    end else begin
      if (state_r == S_RSLT && portAck) result_r <= resMasked;
      if (state_r == S_FIN) done_r <= 1'b1;
      else if (launch || (wrStatus && busWdata[tsm_pkg::ST_DONE])) done_r <= 1'b0;
      if (state_r == S_POLL && portAck && devBusy && pollLast) timeout_r <= 1'b1;
      else if (launch || (wrStatus && busWdata[tsm_pkg::ST_TIMEOUT])) timeout_r <= 1'b0;
      if (reject) rejected_r <= 1'b1;
      else if (wrStatus && busWdata[tsm_pkg::ST_REJECTED]) rejected_r <= 1'b0;
    end
  end

  wire [7:0] statusByte = {4'h0, rejected_r, timeout_r, done_r, busy};
  wire [7:0] rdMux = busAddr == tsm_pkg::HOST_OFS_DATA   ? dataReg_r :
                     busAddr == tsm_pkg::HOST_OFS_ADDR   ? addrReg_r :
                     busAddr == tsm_pkg::HOST_OFS_CMD    ? cmdReg_r  :
                     busAddr == tsm_pkg::HOST_OFS_STATUS ? statusByte :
                     busAddr == tsm_pkg::HOST_OFS_RESULT ? result_r  : 8'h00;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) busRdata <= 32'h0000_0000;
    else if (busRd) busRdata <= {24'h00_0000, rdMux};
    else busRdata <= 32'h0000_0000;
  end
endmodule
`default_nettype wire

//--- rtl/tsm_pkg.sv
// Shared constants, types and opcode helpers for the time-slot switch host controller
// Contract
// - Opcodes 08/18/10/38/30/28/20 write upstream idle value
// - Opcode 88 reads data memory byte
// - Opcode 60 writes one tristate field nibble
// - Opcode 68 writes all tristate fields, address ignored
// - Opcode E0 reads tristate field nibble
// - Opcode 48 writes control memory data field
// - Opcode C8 reads control memory data field
// - Opcode F0 reads control memory code nibble
// - Opcodes 70..77 write pointer plus switching code
// - Opcode 79 marks host channel, stores idle value
// - Poll busy flag to zero before reading result
package tsm_pkg;

  localparam int REF_CLK_MHZ = 250;
  // Device bus timing, ns
  localparam int STROBE_NS   = 100;
  localparam int RECOVER_NS  = 40;
  localparam int STROBE_CYC  = (STROBE_NS * REF_CLK_MHZ + 999) / 1000;
  localparam int RECOVER_CYC = (RECOVER_NS * REF_CLK_MHZ + 999) / 1000;
  localparam int POLL_LIMIT  = 1000;

  // Device register selects and busy flag position
  localparam logic [1:0] DEV_SEL_DATA   = 2'h0;
  localparam logic [1:0] DEV_SEL_ADDR   = 2'h1;
  localparam logic [1:0] DEV_SEL_CMD    = 2'h2;
  localparam logic [1:0] DEV_SEL_STATUS = 2'h3;
  localparam int         DEV_BUSY_BIT   = 0;

  // Host register offsets
  localparam logic [3:0] HOST_OFS_DATA   = 4'h0;
  localparam logic [3:0] HOST_OFS_ADDR   = 4'h1;
  localparam logic [3:0] HOST_OFS_CMD    = 4'h2;
  localparam logic [3:0] HOST_OFS_STATUS = 4'h3;
  localparam logic [3:0] HOST_OFS_RESULT = 4'h4;
  localparam int ST_BUSY     = 0;
  localparam int ST_DONE     = 1;
  localparam int ST_TIMEOUT  = 2;
  localparam int ST_REJECTED = 3;
  localparam logic [7:0] HOST_RESET_BYTE = 8'h00;

  // Memory access opcodes
  localparam logic [7:0] OP_IDLE_8    = 8'h08;
  localparam logic [7:0] OP_IDLE_HI4  = 8'h18;
  localparam logic [7:0] OP_IDLE_LO4  = 8'h10;
  localparam logic [7:0] OP_IDLE_B76  = 8'h38;
  localparam logic [7:0] OP_IDLE_B54  = 8'h30;
  localparam logic [7:0] OP_IDLE_B32  = 8'h28;
  localparam logic [7:0] OP_IDLE_B10  = 8'h20;
  localparam logic [7:0] OP_DM_READ   = 8'h88;
  localparam logic [7:0] OP_TRI_WRITE = 8'h60;
  localparam logic [7:0] OP_TRI_ALL   = 8'h68;
  localparam logic [7:0] OP_TRI_READ  = 8'he0;
  localparam logic [7:0] OP_CM_WRITE  = 8'h48;
  localparam logic [7:0] OP_CM_READ   = 8'hc8;
  localparam logic [7:0] OP_CODE_READ = 8'hf0;
  localparam logic [7:0] OP_SW_BASE   = 8'h70;
  localparam logic [7:0] OP_SW_LAST   = 8'h77;
  localparam logic [7:0] OP_HOST_CHAN = 8'h79;
  localparam logic [7:0] NIBBLE_MASK  = 8'h0f;

  typedef struct packed {
    logic       wr;
    logic [1:0] sel;
    logic [7:0] data;
  } tsm_dev_req_t;

  function automatic logic op_is_read(input logic [7:0] op);
    return op == OP_DM_READ || op == OP_TRI_READ || op == OP_CM_READ || op == OP_CODE_READ;
  endfunction

  function automatic logic op_is_known(input logic [7:0] op);
    return op_is_read(op) || op == OP_IDLE_8 || op == OP_IDLE_HI4 || op == OP_IDLE_LO4
        || op == OP_IDLE_B76 || op == OP_IDLE_B54 || op == OP_IDLE_B32 || op == OP_IDLE_B10
        || op == OP_TRI_WRITE || op == OP_TRI_ALL || op == OP_CM_WRITE || op == OP_HOST_CHAN
        || (op >= OP_SW_BASE && op <= OP_SW_LAST);
  endfunction

endpackage

//--- sim/tdm_slot_switch_memory_access_tb.sv
// Self-checking bench for the host controller against the device model
`timescale 1ns/1ns
`default_nettype none
module tdm_slot_switch_memory_access_tb;
  localparam logic [3:0] HCODE = 4'h9;
  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [3:0]  busAddr = 4'h0;
  logic [31:0] busWdata = 32'h0;
  logic        busWr = 1'b0;
  logic        busRd = 1'b0;
  logic        slow = 1'b0;
  logic        stuck = 1'b0;
  logic [7:0]  res;
  wire logic [31:0] busRdata;
  wire logic        devCsN, devWrN, devRdN, devDataOe;
  wire logic [1:0]  devSel;
  wire logic [7:0]  devDataOut, devDataIn;
  int          protoErr;
  int          n_mismatch = 0;
  int          checks = 0;
  always #2 ref_clk = ~ref_clk;
  tsm_host_ctrl tsm_host_ctrl_i (.ref_clk(ref_clk), .reset_n(reset_n), .busAddr(busAddr), .busWdata(busWdata),
    .busWr(busWr), .busRd(busRd), .busRdata(busRdata), .devCsN(devCsN), .devWrN(devWrN), .devRdN(devRdN),
    .devSel(devSel), .devDataOut(devDataOut), .devDataOe(devDataOe), .devDataIn(devDataIn));
  tsm_dev_model #(.HOST_CODE(HCODE)) tsm_dev_model_i (.ref_clk(ref_clk), .devCsN(devCsN), .devWrN(devWrN),
    .devRdN(devRdN), .devSel(devSel), .devDataOut(devDataOut), .slow(slow), .stuck(stuck), .devDataIn(devDataIn),
    .protoErr(protoErr));
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] want);
    checks++;
    if (seen !== want) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    busWr <= 1'b1;
    busAddr <= a;
    busWdata <= {24'h0, d};
    @(posedge ref_clk);
    busWr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    busRd <= 1'b1;
    busAddr <= a;
    @(posedge ref_clk);
    busRd <= 1'b0;
    #1 v = busRdata;
  endtask
  task automatic issue(input logic [7:0] op, input logic [7:0] d, input logic [7:0] a);
    wr(tsm_pkg::HOST_OFS_DATA, d);
    wr(tsm_pkg::HOST_OFS_ADDR, a);
    wr(tsm_pkg::HOST_OFS_CMD, op);
  endtask
  task automatic finish_op(input logic [3:0] expSt, input int lim = 3000);
    logic [31:0] v = 32'h1;
    int n = 0;
    while (v[tsm_pkg::ST_BUSY] !== 1'b0 && n < lim) begin
      rd(tsm_pkg::HOST_OFS_STATUS, v);
      n++;
    end
    if (n >= lim) begin
      n_mismatch++;
      conclude();
    end
    chk("status", v, {28'h0, expSt});
    rd(tsm_pkg::HOST_OFS_RESULT, v);
    res = v[7:0];
    wr(tsm_pkg::HOST_OFS_STATUS, 8'h0e);
  endtask
  task automatic op_run(input logic [7:0] op, input logic [7:0] d, input logic [7:0] a);
    issue(op, d, a);
    finish_op(4'h2);
  endtask
  task automatic t_reset();
    logic [31:0] v;
    chk("csn", devCsN, 1'b1);
    chk("oe", devDataOe, 1'b0);
    rd(tsm_pkg::HOST_OFS_STATUS, v);
    chk("status", v, 32'h0);
    rd(4'hf, v);
    chk("unmapped", v, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_idle();
    logic [7:0] ops [7] = '{8'h08, 8'h18, 8'h10, 8'h38, 8'h30, 8'h28, 8'h20};
    logic [7:0] msk [7] = '{8'hff, 8'hf0, 8'h0f, 8'hc0, 8'h30, 8'h0c, 8'h03};
    logic [7:0] want = 8'h00;
    for (int i = 0; i < 7; i++) begin
      op_run(ops[i], ~want, 8'h9b);
      want = (want & ~msk[i]) | (~want & msk[i]);
      op_run(tsm_pkg::OP_DM_READ, 8'h00, 8'h9b);
      chk("idle", res, want);
    end
    $display("test idle done");
  endtask
  task automatic t_tri();
    op_run(tsm_pkg::OP_TRI_ALL, 8'hfc, 8'h55);
    op_run(tsm_pkg::OP_TRI_WRITE, 8'h05, 8'h21);
    op_run(tsm_pkg::OP_TRI_READ, 8'h00, 8'h21);
    chk("tri one", res, 8'h05);
    op_run(tsm_pkg::OP_TRI_READ, 8'h00, 8'h7f);
    chk("tri all", res, 8'h0c);
    $display("test tristate done");
  endtask
  task automatic t_cm();
    for (int i = 0; i < 8; i++) begin
      op_run(8'h70 + 8'(i), 8'h40 + 8'(i), 8'h20 + 8'(i));
      op_run(tsm_pkg::OP_CODE_READ, 8'h00, 8'h20 + 8'(i));
      chk("code", res, 8'(i));
    end
    op_run(tsm_pkg::OP_CM_WRITE, 8'ha7, 8'h23);
    op_run(tsm_pkg::OP_CM_READ, 8'h00, 8'h23);
    chk("cm data", res, 8'ha7);
    op_run(tsm_pkg::OP_CODE_READ, 8'h00, 8'h23);
    chk("code kept", res, 8'h03);
    op_run(tsm_pkg::OP_HOST_CHAN, 8'hc3, 8'h30);
    op_run(tsm_pkg::OP_CM_READ, 8'h00, 8'h30);
    chk("host idle", res, 8'hc3);
    op_run(tsm_pkg::OP_CODE_READ, 8'h00, 8'h30);
    chk("host code", res, {4'h0, HCODE});
    $display("test control memory done");
  endtask
  task automatic t_busy();
    logic [31:0] v;
    slow <= 1'b1;
    op_run(tsm_pkg::OP_CM_WRITE, 8'h6e, 8'h44);
    issue(tsm_pkg::OP_CM_READ, 8'h5c, 8'h44);
    wr(tsm_pkg::HOST_OFS_CMD, tsm_pkg::OP_DM_READ);
    wr(tsm_pkg::HOST_OFS_DATA, 8'h11);
    finish_op(4'ha);
    chk("slow read", res, 8'h6e);
    rd(tsm_pkg::HOST_OFS_DATA, v);
    chk("data kept", v, 32'h5c);
    slow <= 1'b0;
    wr(tsm_pkg::HOST_OFS_CMD, 8'h99);
    rd(tsm_pkg::HOST_OFS_STATUS, v);
    chk("unknown op", v, 32'h8);
    wr(tsm_pkg::HOST_OFS_STATUS, 8'h0e);
    chk("model protocol", protoErr, 32'h0);
    $display("test busy done");
  endtask
  task automatic t_timeout();
    // Device holds busy for 40000 cycles, past the poll budget, so the controller must give up after its poll limit
    stuck <= 1'b1;
    issue(tsm_pkg::OP_CM_WRITE, 8'h3c, 8'h45);
    finish_op(4'h6, 25000);
    stuck <= 1'b0;
    $display("test timeout done");
  endtask
  initial begin
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    t_reset();
    t_idle();
    t_tri();
    t_cm();
    t_busy();
    t_timeout();
    conclude();
  end
endmodule
`default_nettype wire

//--- sim/tsm_dev_model.sv
// Behavioural model of the switch's memory access registers and memories
`timescale 1ns/1ns
`default_nettype none
module tsm_dev_model #(
  parameter logic [3:0] HOST_CODE = 4'h9
) (
  input  wire logic       ref_clk,
  input  wire logic       devCsN,
  input  wire logic       devWrN,
  input  wire logic       devRdN,
  input  wire logic [1:0] devSel,
  input  wire logic [7:0] devDataOut,
  input  wire logic       slow,
  input  wire logic       stuck,
  output logic [7:0]      devDataIn,
  output int              protoErr
);
  logic [7:0] dataReg = 8'h00;
  logic [7:0] addrReg = 8'h00;
  // Flat 8-bit address spans any port split or double slot
  logic [7:0] dm [256];
  logic [7:0] cmData [256];
  logic [3:0] triFld [256];
  logic [3:0] code [256];
  logic       wrPrev = 1'b1;
  logic       rdPrev = 1'b1;
  int         busyCnt = 0;
  wire logic  busy = busyCnt != 0;
  wire logic [7:0] rdVal = devSel == 2'h3 ? {7'h00, busy} : devSel == 2'h1 ? addrReg : dataReg;
  wire logic [7:0] mask = devDataOut == 8'h08 ? 8'hff : devDataOut == 8'h18 ? 8'hf0 : devDataOut == 8'h10 ? 8'h0f
                        : devDataOut == 8'h38 ? 8'hc0 : devDataOut == 8'h30 ? 8'h30 : devDataOut == 8'h28 ? 8'h0c : 8'h03;
  initial begin
    devDataIn = 8'h00;
    protoErr = 0;
    for (int i = 0; i < 256; i++) begin
      dm[i] = 8'h00;
      cmData[i] = 8'h00;
      triFld[i] = 4'h0;
      code[i] = 4'h0;
    end
  end
  always @(posedge ref_clk) begin
    wrPrev <= devWrN;
    rdPrev <= devRdN;
    if (busy) busyCnt <= busyCnt - 1;
    // Released bus toggles so a stale byte is never mistaken for data
    devDataIn <= (!devCsN && !devRdN) ? rdVal : ~devDataIn;
    if (!devCsN && !devRdN && rdPrev && devSel == 2'h0 && busy) protoErr <= protoErr + 1;
    if (!devCsN && !devWrN && wrPrev) begin
      if (busy) protoErr <= protoErr + 1;
      if (devSel == 2'h0) dataReg = devDataOut;
      if (devSel == 2'h1) addrReg = devDataOut;
      if (devSel == 2'h2) begin
        // Stuck outlasts the controller's full poll budget
        busyCnt <= stuck ? 40000 : slow ? 300 : 2;
        case (devDataOut)
          8'h08, 8'h18, 8'h10, 8'h38, 8'h30, 8'h28, 8'h20: dm[addrReg] = (dm[addrReg] & ~mask) | (dataReg & mask);
          8'h88: dataReg = dm[addrReg];
          8'h60: triFld[addrReg] = dataReg[3:0];
          8'h68: for (int i = 0; i < 256; i++) triFld[i] = dataReg[3:0];
          8'he0: dataReg = {~triFld[addrReg], triFld[addrReg]};
          8'h48: cmData[addrReg] = dataReg;
          8'hc8: dataReg = cmData[addrReg];
          8'hf0: dataReg = {~code[addrReg], code[addrReg]};
          8'h79: begin
            cmData[addrReg] = dataReg;
            code[addrReg] = HOST_CODE;
          end
          default: begin
            cmData[addrReg] = dataReg;
            code[addrReg] = {1'b0, devDataOut[2:0]};
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

//--- sim/tsm_host_ctrl_checker.sv
// Protocol checker for the host controller's device pins and host bus
`timescale 1ns/1ns
`default_nettype none
module tsm_host_ctrl_checker (
  input wire logic        ref_clk,
  input wire logic        reset_n,
  input wire logic [3:0]  busAddr,
  input wire logic [31:0] busWdata,
  input wire logic        busWr,
  input wire logic        busRd,
  input wire logic [31:0] busRdata,
  input wire logic        devCsN,
  input wire logic        devWrN,
  input wire logic        devRdN,
  input wire logic [1:0]  devSel,
  input wire logic [7:0]  devDataOut,
  input wire logic        devDataOe,
  input wire logic [7:0]  devDataIn
);
  logic [7:0] lowCnt_r;
  logic [1:0] lastWrSel_r;
  logic [1:0] lastRdSel_r;
  logic       lastBusy_r;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // Last strobe cycle wins, so a status read shows its final busy value
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      lowCnt_r    <= 8'h00;
      lastWrSel_r <= 2'h0;
      lastRdSel_r <= 2'h0;
      lastBusy_r  <= 1'b0;
    end else begin
      lowCnt_r <= (devWrN && devRdN) ? 8'h00 : lowCnt_r + 8'h01;
      if (!devWrN) lastWrSel_r <= devSel;
      if (!devRdN) lastRdSel_r <= devSel;
      if (!devRdN) lastBusy_r <= devDataIn[tsm_pkg::DEV_BUSY_BIT];
    end
  end
  property p_strobe_len; ($rose(devWrN) || $rose(devRdN)) |-> lowCnt_r == 8'(tsm_pkg::STROBE_CYC); endproperty
  a_strobe_len: assert property (p_strobe_len) else $error("strobe length wrong");
  property p_strobe_cs; (!devWrN || !devRdN) |-> !devCsN && (devWrN || devRdN) && devDataOe == !devWrN; endproperty
  a_strobe_cs: assert property (p_strobe_cs) else $error("strobe without select or bad drive");
  property p_sel_hold; (!devCsN && !$past(devCsN)) |-> $stable(devSel) && $stable(devDataOut); endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("select or data moved in access");
  property p_recover; $rose(devCsN) |-> devCsN [*8]; endproperty
  a_recover: assert property (p_recover) else $error("recovery too short");
  property p_cmd_order; ($fell(devWrN) && devSel == tsm_pkg::DEV_SEL_CMD) |->
    lastWrSel_r == (devDataOut == tsm_pkg::OP_TRI_ALL ? tsm_pkg::DEV_SEL_DATA : tsm_pkg::DEV_SEL_ADDR); endproperty
  a_cmd_order: assert property (p_cmd_order) else $error("command not after its operands");
  property p_poll_first; ($fell(devRdN) && devSel == tsm_pkg::DEV_SEL_DATA) |->
    lastRdSel_r == tsm_pkg::DEV_SEL_STATUS && !lastBusy_r; endproperty
  a_poll_first: assert property (p_poll_first) else $error("result read before idle status");
  property p_rdata_idle; !$past(busRd) |-> busRdata == 32'h0; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
  property p_rdata_hi; $past(busRd) |-> busRdata[31:8] == 24'h0; endproperty
  a_rdata_hi: assert property (p_rdata_hi) else $error("read data upper bits set");
endmodule
bind tsm_host_ctrl tsm_host_ctrl_checker tsm_host_ctrl_checker_i (.ref_clk(ref_clk), .reset_n(reset_n),
  .busAddr(busAddr), .busWdata(busWdata), .busWr(busWr), .busRd(busRd), .busRdata(busRdata), .devCsN(devCsN),
  .devWrN(devWrN), .devRdN(devRdN), .devSel(devSel), .devDataOut(devDataOut), .devDataOe(devDataOe),
  .devDataIn(devDataIn));
`default_nettype wire
